// File: core/serial_modem_status_lines.sv
// Purpose: modem status/control lines and second-port pin sharing
// Assumes: control bits and status read strobe come from host logic
// Notes: status byte is registered; read clears deltas on the next edge
`timescale 1ns/100ps
module serial_modem_status_lines
  import modem_lines_pkg::*;
#(
  parameter int PINS = modem_lines_pkg::PORT2_PINS
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic carrier_detect_in_n, // modem carrier, low active
  input wire logic ring_indicator_in_n, // modem ring, low active
  input wire logic clear_to_send_in_n, // modem cts, low active
  input wire logic data_set_ready_in_n, // modem dsr, low active
  output logic request_to_send_out_n, // rts pin, low active
  output logic terminal_ready_out_n, // dtr pin, low active
  input wire logic [7:0] modem_control_reg, // control byte
  input wire logic [7:0] interrupt_enable_reg, // enable byte
  input wire logic status_read, // one-cycle status read strobe
  output logic [7:0] modem_status_reg, // status byte
  output logic modem_irq, // modem status interrupt level
  input wire logic [PINS-1:0] port2_gpio_sel, // 1 = general I/O
  input wire logic [PINS-1:0] port2_gpio_od, // 1 = open-drain
  input wire logic [PINS-1:0] port2_gpio_dir, // 1 = output
  input wire logic [PINS-1:0] port2_gpio_dout, // gpio out data
  output logic [PINS-1:0] port2_gpio_din, // gpio in data
  input wire logic [PINS-1:0] port2_pin_in, // pad input levels
  output logic [PINS-1:0] port2_pin_out, // pad output levels
  output logic [PINS-1:0] port2_pin_oe, // pad drive enables
  input wire logic port2_txd_func, // uart transmit data
  input wire logic port2_rts_n_func, // uart rts, low active
  input wire logic port2_dtr_n_func, // uart dtr, low active
  output logic [PINS-1:0] port2_func_in, // serial function inputs
  input wire logic ir_on_port2, // 1 = infrared on rxd/txd pins
  input wire logic infrared_transmit_func, // ir engine transmit
  output logic infrared_receive_func, // ir engine receive
  input wire logic [1:0] ir_gpio_sel, // 1 = general I/O on ir pin
  input wire logic [1:0] ir_gpio_od, // ir pin open-drain
  input wire logic [1:0] ir_gpio_dir, // ir pin gpio direction
  input wire logic [1:0] ir_gpio_dout, // ir pin gpio data
  output logic [1:0] ir_gpio_din, // ir pin gpio input
  input wire logic infrared_receive_in, // dedicated ir rx pad in
  input wire logic infrared_transmit_pad_in, // dedicated ir tx pad in
  output logic [1:0] ir_pin_out, // ir pads out, [1]=tx
  output logic [1:0] ir_pin_oe // ir pads enable
);
  import modem_lines_pkg::*;

  // pin indices are fixed, so only the full group is served
  if (PINS != PORT2_PINS) begin : g_bad_pins
    $error("PINS must equal PORT2_PINS");
  end

  // --------------------------------------------------------------
  // modem status
  // --------------------------------------------------------------
  // packed {dcd, ri, dsr, cts}, all low active
  logic [3:0] line_n;
  logic [3:0] prev_n;
  logic [3:0] next_prev_n;
  logic [7:0] next_status;
  logic next_irq;
  logic [3:0] delta;
  logic [3:0] change;

  input_sync #(
    .WIDTH(4),
    .INIT(4'hF)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({carrier_detect_in_n, ring_indicator_in_n,
               data_set_ready_in_n, clear_to_send_in_n}),
    .sync_out(line_n)
  );

  always_comb begin
    next_prev_n = line_n;
    // low-to-high on the pin level itself, as the modem drives it
    delta = line_n & ~prev_n;
    change = line_n ^ prev_n;
    next_status = modem_status_reg;
    // set wins over the read clear so no edge is lost
    if (status_read) begin
      next_status[STAT_DDCD] = 1'b0;
      next_status[STAT_TERI] = 1'b0;
      next_status[STAT_DDSR] = 1'b0;
      next_status[STAT_DCTS] = 1'b0;
    end
    if (delta[3]) next_status[STAT_DDCD] = 1'b1;
    if (delta[2]) next_status[STAT_TERI] = 1'b1;
    if (delta[1]) next_status[STAT_DDSR] = 1'b1;
    if (delta[0]) next_status[STAT_DCTS] = 1'b1;
    next_status[STAT_DCD] = ~line_n[3];
    next_status[STAT_RI] = ~line_n[2];
    next_status[STAT_DSR] = ~line_n[1];
    next_status[STAT_CTS] = ~line_n[0];
    // interrupt holds while any change is pending since the last read
    next_irq = modem_irq;
    if (status_read) next_irq = 1'b0;
    if (interrupt_enable_reg[IRQEN_MODEM] && (change[3] || change[2]))
      next_irq = 1'b1;
    if (interrupt_enable_reg[IRQEN_MODEM] && (change[1] || change[0]))
      next_irq = 1'b1;
    if (!interrupt_enable_reg[IRQEN_MODEM]) next_irq = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_n <= 4'hF;
      modem_status_reg <= STAT_RESET;
      modem_irq <= 1'b0;
    end else begin
      prev_n <= next_prev_n;
      modem_status_reg <= next_status;
      modem_irq <= next_irq;
    end
  end

  // --------------------------------------------------------------
  // modem control outputs
  // --------------------------------------------------------------
  logic next_rts_n;
  logic next_dtr_n;

  always_comb begin
    next_rts_n = ~modem_control_reg[CTRL_RTS];
    next_dtr_n = ~modem_control_reg[CTRL_DTR];
    if (modem_control_reg[CTRL_LOOP]) begin
      next_rts_n = 1'b1;
      next_dtr_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      request_to_send_out_n <= 1'b1;
      terminal_ready_out_n <= 1'b1;
    end else begin
      request_to_send_out_n <= next_rts_n;
      terminal_ready_out_n <= next_dtr_n;
    end
  end

  // --------------------------------------------------------------
  // pin sharing
  // --------------------------------------------------------------
  logic [PINS-1:0] pin_sync;
  logic [1:0] ir_sync;
  logic [PINS-1:0] next_out;
  logic [PINS-1:0] next_oe;
  logic [PINS-1:0] func_out;
  logic [PINS-1:0] func_oe;
  logic [1:0] next_ir_out;
  logic [1:0] next_ir_oe;
  logic next_ir_rx;

  input_sync #(
    .WIDTH(PINS + 2),
    .INIT('1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({infrared_transmit_pad_in, infrared_receive_in,
               port2_pin_in}),
    .sync_out({ir_sync, pin_sync})
  );

  // general output: push-pull, or open-drain driving only the low level
  function automatic logic gpio_oe(input logic dir, input logic od,
                                   input logic dout);
    return dir && (!od || !dout);
  endfunction

  always_comb begin
    func_out = '1;
    func_oe = '0;
    func_out[PIN_TXD] = ir_on_port2 ? infrared_transmit_func
                                    : port2_txd_func;
    func_out[PIN_RTS] = port2_rts_n_func;
    func_out[PIN_DTR] = port2_dtr_n_func;
    func_oe[PIN_TXD] = 1'b1;
    func_oe[PIN_RTS] = 1'b1;
    func_oe[PIN_DTR] = 1'b1;
    next_out = '1;
    next_oe = '0;
    next_ir_out = 2'h3;
    next_ir_oe = 2'h0;
    for (int i = 0; i < PINS; i++) begin
      if (port2_gpio_sel[i]) begin
        next_out[i] = port2_gpio_od[i] ? 1'b0 : port2_gpio_dout[i];
        next_oe[i] = gpio_oe(port2_gpio_dir[i], port2_gpio_od[i],
                             port2_gpio_dout[i]);
      end else begin
        next_out[i] = func_out[i];
        next_oe[i] = func_oe[i];
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (ir_gpio_sel[j] || ir_on_port2) begin
        next_ir_out[j] = ir_gpio_od[j] ? 1'b0 : ir_gpio_dout[j];
        next_ir_oe[j] = ir_gpio_sel[j] &&
                        gpio_oe(ir_gpio_dir[j], ir_gpio_od[j],
                                ir_gpio_dout[j]);
      end else begin
        next_ir_out[j] = (j == 1) ? infrared_transmit_func : 1'b1;
        next_ir_oe[j] = (j == 1);
      end
    end
    next_ir_rx = ir_on_port2 ? pin_sync[PIN_RXD] : ir_sync[0];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port2_pin_out <= '1;
      port2_pin_oe <= '0;
      ir_pin_out <= 2'h3;
      ir_pin_oe <= 2'h0;
      port2_gpio_din <= '1;
      port2_func_in <= '1;
      ir_gpio_din <= 2'h3;
      infrared_receive_func <= 1'b1;
    end else begin
      port2_pin_out <= next_out;
      port2_pin_oe <= next_oe;
      ir_pin_out <= next_ir_out;
      ir_pin_oe <= next_ir_oe;
      port2_gpio_din <= pin_sync;
      port2_func_in <= pin_sync;
      ir_gpio_din <= ir_sync;
      infrared_receive_func <= next_ir_rx;
    end
  end
endmodule // serial_modem_status_lines

// File: core/modem_lines_pkg.sv
// Purpose: shared constants for the serial modem status and pin mux block
// Assumes: one clock domain, 8-bit status and control bytes
// Notes: bit positions of status, control and enable bytes
package modem_lines_pkg;
  // modem status byte
  localparam int STAT_DCTS = 0;
  localparam int STAT_DDSR = 1;
  localparam int STAT_TERI = 2;
  localparam int STAT_DDCD = 3;
  localparam int STAT_CTS = 4;
  localparam int STAT_DSR = 5;
  localparam int STAT_RI = 6;
  localparam int STAT_DCD = 7;
  // modem control byte
  localparam int CTRL_DTR = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_LOOP = 4;
  // interrupt enable byte
  localparam int IRQEN_MODEM = 3;
  // reset values and synchroniser depth
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SYNC_STAGES = 3;
  // pin-group indices of the second port
  localparam int PIN_RXD = 0;
  localparam int PIN_TXD = 1;
  localparam int PIN_RTS = 2;
  localparam int PIN_CTS = 3;
  localparam int PIN_DTR = 4;
  localparam int PIN_DSR = 5;
  localparam int PIN_DCD = 6;
  localparam int PIN_RI = 7;
  localparam int PORT2_PINS = 8;
endpackage

// File: core/input_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: value updates once stages two and three agree
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic [WIDTH-1:0] async_in, // raw pins
  output logic [WIDTH-1:0] sync_out // filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  // refuse a zero-width instance at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("input_sync: WIDTH must be positive");
  end

  always_comb begin
    next_sync_out = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) next_sync_out[i] = stage3[i];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_sync_out;
    end
  end
endmodule // input_sync

// File: bench/modem_lines_monitor.sv
// Purpose: port checks for the modem status and pin sharing block
// Assumes: bound to the top module from tb
// Notes: settle windows cover sync stages plus the status register
`timescale 1ns/100ps
module modem_lines_monitor
  import modem_lines_pkg::*;
#(parameter int PINS = 8) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic carrier_detect_in_n, // carrier
  input wire logic ring_indicator_in_n, // ring
  input wire logic clear_to_send_in_n, // cts
  input wire logic data_set_ready_in_n, // dsr
  input wire logic request_to_send_out_n, // rts
  input wire logic terminal_ready_out_n, // dtr
  input wire logic [7:0] modem_control_reg, // control
  input wire logic [7:0] interrupt_enable_reg, // enable
  input wire logic status_read, // read strobe
  input wire logic [7:0] modem_status_reg, // status
  input wire logic modem_irq, // irq
  input wire logic [PINS-1:0] port2_gpio_sel, // gpio select
  input wire logic [PINS-1:0] port2_gpio_od, // open-drain
  input wire logic [PINS-1:0] port2_gpio_dir, // direction
  input wire logic [PINS-1:0] port2_gpio_dout, // gpio data
  input wire logic [PINS-1:0] port2_pin_oe // pad enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0] lines_n;
  assign lines_n = {carrier_detect_in_n, ring_indicator_in_n,
    data_set_ready_in_n, clear_to_send_in_n};
  a_rts_follow: assert property (request_to_send_out_n ==
    ($past(modem_control_reg[CTRL_LOOP]) |
     !$past(modem_control_reg[CTRL_RTS])))
    else $error("rts pin does not follow control byte");
  a_dtr_follow: assert property (terminal_ready_out_n ==
    ($past(modem_control_reg[CTRL_LOOP]) |
     !$past(modem_control_reg[CTRL_DTR])))
    else $error("dtr pin does not follow control byte");
  a_levels_track: assert property ($stable(lines_n)[*8] |->
    modem_status_reg[7:4] == ~lines_n)
    else $error("status levels differ from settled pins");
  a_carrier_delta: assert property ($rose(carrier_detect_in_n) |->
    ##[1:6] modem_status_reg[STAT_DDCD])
    else $error("carrier rise not flagged");
  a_ring_delta: assert property ($rose(ring_indicator_in_n) |->
    ##[1:6] modem_status_reg[STAT_TERI])
    else $error("ring rise not flagged");
  a_cts_delta: assert property ($rose(clear_to_send_in_n) |->
    ##[1:6] modem_status_reg[STAT_DCTS])
    else $error("cts rise not flagged");
  a_dsr_delta: assert property ($rose(data_set_ready_in_n) |->
    ##[1:6] modem_status_reg[STAT_DDSR])
    else $error("dsr rise not flagged");
  a_read_clears: assert property ($stable(lines_n)[*8] ##0 status_read
    |=> modem_status_reg[3:0] == 4'h0)
    else $error("status read left a change flag");
  a_irq_change: assert property ($changed(lines_n) && !status_read &&
    interrupt_enable_reg[IRQEN_MODEM] |-> ##[1:6] modem_irq)
    else $error("line change raised no interrupt");
  a_irq_gated: assert property (!interrupt_enable_reg[IRQEN_MODEM] &&
    !$past(interrupt_enable_reg[IRQEN_MODEM]) |-> !modem_irq)
    else $error("interrupt while disabled");
  a_od_enable: assert property ($past(port2_gpio_sel[1]) &&
    $past(port2_gpio_od[1]) |-> port2_pin_oe[1] ==
    ($past(port2_gpio_dir[1]) && !$past(port2_gpio_dout[1])))
    else $error("open-drain enable wrong");
endmodule // modem_lines_monitor

// File: bench/modem_partner.sv
// Purpose: external modem driving the four handshake inputs
// Assumes: bench asks for asserted lines, order {dcd,ri,dsr,cts}
// Notes: levels change just after an edge and are held by the bench
`timescale 1ns/100ps
module modem_partner (
  input wire logic clk_sys, // clock
  input wire logic [3:0] assert_lines, // 1 = line asserted
  output logic [3:0] lines_n // pins, low active
);
  initial lines_n = 4'hF;
  always @(posedge clk_sys) lines_n <= ~assert_lines;
endmodule // modem_partner

// File: bench/tb.sv
// Purpose: self-checking bench for serial_modem_status_lines
// Assumes: 100 MHz clock, reset held 20 cycles
// Notes: row table for status cases, hand tests afterwards
`timescale 1ns/100ps
module tb;
  import modem_lines_pkg::*;
  logic clk_sys = 0, rst = 1, st_rd = 0, ir_p2 = 0, ir_tx = 0, ir_pad = 1;
  logic rts_n, dtr_n, irq, ir_rx;
  logic [3:0] want = 0, ln;
  logic [7:0] ctrl = 0, irq_en = 0, sel = 0, od = 0, dir = 0, dout = 0;
  logic [7:0] pin_in = 8'hFF, stat, din, fin, pout, poe;
  logic [2:0] fn = 0;
  logic [1:0] ir_din, ir_out, ir_oe;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  // {asserted lines, expected change flags, expected irq}
  logic [8:0] rows [5] = '{9'h1E1, 9'h01F, 9'h141, 9'h0B5, 9'h0A0};
  modem_partner u_modem (.clk_sys(clk_sys), .assert_lines(want), .lines_n(ln));
  serial_modem_status_lines u_dut (.clk_sys(clk_sys), .rst(rst),
    .carrier_detect_in_n(ln[3]), .ring_indicator_in_n(ln[2]),
    .data_set_ready_in_n(ln[1]), .clear_to_send_in_n(ln[0]),
    .request_to_send_out_n(rts_n), .terminal_ready_out_n(dtr_n),
    .modem_control_reg(ctrl), .interrupt_enable_reg(irq_en),
    .status_read(st_rd), .modem_status_reg(stat), .modem_irq(irq),
    .port2_gpio_sel(sel), .port2_gpio_od(od), .port2_gpio_dir(dir),
    .port2_gpio_dout(dout), .port2_gpio_din(din), .port2_pin_in(pin_in),
    .port2_pin_out(pout), .port2_pin_oe(poe), .port2_txd_func(fn[0]),
    .port2_rts_n_func(fn[1]), .port2_dtr_n_func(fn[2]),
    .port2_func_in(fin), .ir_on_port2(ir_p2), .infrared_transmit_func(ir_tx),
    .infrared_receive_func(ir_rx), .ir_gpio_sel(sel[1:0]),
    .ir_gpio_od(od[1:0]), .ir_gpio_dir(dir[1:0]), .ir_gpio_dout(dout[1:0]),
    .ir_gpio_din(ir_din), .infrared_receive_in(ir_pad),
    .infrared_transmit_pad_in(pin_in[7]), .ir_pin_out(ir_out),
    .ir_pin_oe(ir_oe));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    tick(20);
    check({rts_n, dtr_n, irq}, 8'h06);
    check(stat, STAT_RESET);
    $display("reset test done");
    @(posedge clk_sys) rst <= 0;
    @(posedge clk_sys) irq_en <= 8'h08;
    foreach (rows[i]) begin
      @(posedge clk_sys) want <= rows[i][8:5];
      tick(10);
      check(stat, rows[i][8:1]);
      check(irq, rows[i][0]);
      @(posedge clk_sys) st_rd <= 1;
      @(posedge clk_sys) st_rd <= 0;
      tick(1);
      check({stat[3:0], irq}, 8'h00);
      $display("status row %0d done", i);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys) ctrl <= {3'h0, i[2], 2'h0, i[1:0]};
      tick(2);
      check({rts_n, dtr_n}, {i[2] | !i[1], i[2] | !i[0]});
    end
    $display("control test done");
    @(posedge clk_sys) irq_en <= 8'h00;
    want <= 4'h8;
    tick(10);
    check(irq, 8'h00);
    @(posedge clk_sys) irq_en <= 8'h08;
    tick(3);
    check(irq, 8'h00);
    $display("masked test done");
    // read strobe lands on the edge that latches a carrier rise
    @(posedge clk_sys) want <= 4'h0;
    repeat (5) @(posedge clk_sys);
    st_rd <= 1;
    @(posedge clk_sys) st_rd <= 0;
    tick(1);
    check({stat[3:0], irq}, 8'h11);
    $display("collision test done");
    @(posedge clk_sys) sel <= 8'h02;
    dir <= 8'h02;
    dout <= 8'h02;
    tick(2);
    check({pout[1], poe[1]}, 8'h03);
    @(posedge clk_sys) od <= 8'h02;
    tick(2);
    check({pout[1], poe[1]}, 8'h00);
    @(posedge clk_sys) dout <= 8'h00;
    pin_in <= 8'h7E;
    tick(6);
    check({pout[1], poe[1]}, 8'h01);
    check(din, 8'h7E);
    check(fin, 8'h7E);
    @(posedge clk_sys) sel <= 8'h00;
    fn <= 3'h5;
    tick(2);
    check({pout[PIN_DTR], pout[PIN_RTS], pout[PIN_TXD]}, 8'h05);
    check(poe, 8'h16);
    $display("pin sharing test done");
    @(posedge clk_sys) ir_tx <= 1;
    ir_pad <= 0;
    tick(6);
    check({ir_out[1], ir_rx}, 8'h02);
    check({ir_out, ir_oe, ir_din}, 8'h38);
    @(posedge clk_sys) ir_p2 <= 1;
    ir_tx <= 0;
    pin_in <= 8'hFF;
    tick(6);
    check({pout[PIN_TXD], ir_rx}, 8'h01);
    check({ir_out, ir_oe, ir_din}, 8'h02);
    $display("infrared routing test done");
    tally_and_finish;
  end
endmodule // tb
bind serial_modem_status_lines modem_lines_monitor #(.PINS(PINS)) u_mon (
  .clk_sys, .rst, .carrier_detect_in_n, .ring_indicator_in_n,
  .clear_to_send_in_n, .data_set_ready_in_n, .request_to_send_out_n,
  .terminal_ready_out_n, .modem_control_reg, .interrupt_enable_reg,
  .status_read, .modem_status_reg, .modem_irq, .port2_gpio_sel,
  .port2_gpio_od, .port2_gpio_dir, .port2_gpio_dout, .port2_pin_oe);
